// File: hdl/mac_station_mgmt_and_counters.sv
// station management registers, phy management link and mac event counters
//
// Behaviour
// - 16-bit management data register holds write value or returned read value
// - control bits 4:0 pick the register inside the phy
// - control bits 9:5 give the phy address
// - control bit 10 set means write, clear means read
// - software writes busy bit 11 to start; hardware clears it when done
// - skip_preamble bit 12 drops the preamble, otherwise it is sent
// - mdc period is divider field times two plus sixteen clocks; resets 100
// - management registers never touch the mac data path
// - each of 21 cam mask bits enables its cam location
// - mask bits above the implemented cam entries are ignored
// - reading the missed counter returns it and clears it
// - missed counter step 7fff to 8000 flags mac control and may interrupt
// - software may preload the missed counter near rollover
// - missed counter counts drops from overflow, parity and receive disabled
// - alignment tally counts packets whose status shows alignment error
// - checksum tally counts crc errors without an alignment error, not other errors
// - read-only 16-bit count of slots our transmitter was paused
// - separate readable 16-bit remote pause counter
// - remote counter counts slots the far station was paused by us
`timescale 1ns/1ps
module mac_station_mgmt_and_counters
  import station_mgmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  output logic [CAM_SLOTS-1:0] cam_location_valid_bits,
  input wire logic drop_fifo_overflow,
  input wire logic drop_fifo_parity,
  input wire logic drop_rx_disabled,
  input wire logic rx_status_valid,
  input wire logic rx_status_align_err,
  input wire logic rx_status_crc_err,
  input wire logic rx_pause_slot,
  input wire logic remote_pause_slot,
  input wire logic missed_int_enable,
  output logic missed_rollover,
  output logic missed_irq
);

  typedef struct packed {
    logic [15:0] data;
    logic [4:0] reg_addr;
    logic [4:0] phy_addr;
    logic is_write;
    logic busy;
    logic skip_pre;
    logic [2:0] divider;
    logic [CAM_SLOTS-1:0] cam_mask;
    logic [15:0] missed;
    logic [15:0] align_tally;
    logic [15:0] checksum_tally;
    logic [15:0] rx_pause;
    logic [15:0] remote_pause;
    logic [31:0] rdata;
    logic rd_ready;
    logic rd_err;
    logic start;
    logic rollover;
  } regs_type;

  regs_type r_reg;
  regs_type r_next;

  logic setup;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic missed_event;
  logic [15:0] missed_base;
  logic [15:0] missed_step;
  logic eng_done;
  logic [15:0] eng_rdata;
  logic [31:0] control_view;

  // the engine only ever sees the management fields, never mac data-path state
  mgmt_serial_engine engine (
    .pclk(pclk),
    .presetn(presetn),
    .start(r_reg.start),
    .is_write(r_reg.is_write),
    .skip_preamble(r_reg.skip_pre),
    .mgmt_clock_divider(r_reg.divider),
    .phy_addr(r_reg.phy_addr),
    .reg_addr(r_reg.reg_addr),
    .wdata(r_reg.data),
    .mdio_in(mdio_in),
    .done(eng_done),
    .rdata(eng_rdata),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n)
  );

  always_comb
  begin
    control_view = '0;
    control_view[CTL_REG_LSB +: 5] = r_reg.reg_addr;
    control_view[CTL_PHY_LSB +: 5] = r_reg.phy_addr;
    control_view[CTL_WRITE_BIT] = r_reg.is_write;
    control_view[CTL_BUSY_BIT] = r_reg.busy;
    control_view[CTL_SKIP_PRE_BIT] = r_reg.skip_pre;
    control_view[CTL_DIV_LSB +: 3] = r_reg.divider;
  end

  always_comb
  begin
    unique case (paddr)
      OFF_DATA, OFF_CONTROL, OFF_CAM_MASK, OFF_MISSED, OFF_RX_PAUSE,
      OFF_REMOTE_PAUSE, OFF_ALIGN_TALLY, OFF_CHECKSUM_TALLY: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // reads are captured in the setup cycle, so every access phase lasts one cycle
  assign setup = psel && !penable;
  assign access_done = psel && penable;
  assign wr_done = access_done && pwrite && mapped;
  assign rd_done = access_done && !pwrite && mapped;

  assign missed_event = drop_fifo_overflow || drop_fifo_parity || drop_rx_disabled;

  always_comb
  begin
    r_next = r_reg;
    r_next.start = 1'b0;
    r_next.rollover = 1'b0;
    r_next.rd_ready = 1'b0;

    if (setup)
    begin
      r_next.rd_ready = 1'b1;
      r_next.rd_err = !mapped;
      r_next.rdata = '0;
      unique case (paddr)
        OFF_DATA: r_next.rdata = {16'h0000, r_reg.data};
        OFF_CONTROL: r_next.rdata = control_view;
        OFF_CAM_MASK: r_next.rdata = 32'(r_reg.cam_mask);
        OFF_MISSED: r_next.rdata = {16'h0000, r_reg.missed};
        OFF_RX_PAUSE: r_next.rdata = {16'h0000, r_reg.rx_pause};
        OFF_REMOTE_PAUSE: r_next.rdata = {16'h0000, r_reg.remote_pause};
        OFF_ALIGN_TALLY: r_next.rdata = {16'h0000, r_reg.align_tally};
        OFF_CHECKSUM_TALLY: r_next.rdata = {16'h0000, r_reg.checksum_tally};
        default: r_next.rdata = '0;
      endcase
    end

    if (wr_done && paddr == OFF_DATA)
      r_next.data = pwdata[15:0];

    // control is frozen while a transfer runs so the frame cannot change mid-flight
    if (wr_done && paddr == OFF_CONTROL && !r_reg.busy)
    begin
      r_next.reg_addr = pwdata[CTL_REG_LSB +: 5];
      r_next.phy_addr = pwdata[CTL_PHY_LSB +: 5];
      r_next.is_write = pwdata[CTL_WRITE_BIT];
      r_next.skip_pre = pwdata[CTL_SKIP_PRE_BIT];
      r_next.divider = pwdata[CTL_DIV_LSB +: 3];
      r_next.busy = pwdata[CTL_BUSY_BIT];
      r_next.start = pwdata[CTL_BUSY_BIT];
    end

    if (eng_done)
    begin
      if (!r_reg.is_write)
        r_next.data = eng_rdata;
      r_next.busy = 1'b0;
    end

    if (wr_done && paddr == OFF_CAM_MASK)
      r_next.cam_mask = pwdata[CAM_SLOTS-1:0];

    // a read clears only what was reported; events after the snapshot survive
    missed_base = r_reg.missed;
    if (rd_done && paddr == OFF_MISSED)
      missed_base = r_reg.missed - r_reg.rdata[15:0];
    if (wr_done && paddr == OFF_MISSED)
      missed_base = pwdata[15:0];
    missed_step = missed_base + 16'(missed_event);
    r_next.missed = missed_step;
    if (missed_event && missed_base == MISSED_ROLL_FROM)
      r_next.rollover = 1'b1;

    if (rx_status_valid && rx_status_align_err)
      r_next.align_tally = r_reg.align_tally + 16'h0001;
    if (rx_status_valid && rx_status_crc_err && !rx_status_align_err)
      r_next.checksum_tally = r_reg.checksum_tally + 16'h0001;

    if (rx_pause_slot)
      r_next.rx_pause = r_reg.rx_pause + 16'h0001;
    if (remote_pause_slot)
      r_next.remote_pause = r_reg.remote_pause + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '0;
      r_reg.data <= DATA_RESET[15:0];
      r_reg.divider <= DIV_RESET;
      r_reg.cam_mask <= CAM_MASK_RESET[CAM_SLOTS-1:0];
      r_reg.missed <= COUNT_RESET;
      r_reg.align_tally <= COUNT_RESET;
      r_reg.checksum_tally <= COUNT_RESET;
      r_reg.rx_pause <= COUNT_RESET;
      r_reg.remote_pause <= COUNT_RESET;
    end
    else
      r_reg <= r_next;
  end

  // entries beyond the built cam never show as valid
  genvar slot;
  generate
    for (slot = 0; slot < CAM_SLOTS; slot++)
    begin : cam_gate
      if (slot < CAM_IMPLEMENTED)
      begin : built
        assign cam_location_valid_bits[slot] = r_reg.cam_mask[slot];
      end
      else
      begin : absent
        assign cam_location_valid_bits[slot] = 1'b0;
      end
    end
  endgenerate

  assign pready = access_done && r_reg.rd_ready;
  assign pslverr = access_done && r_reg.rd_ready && r_reg.rd_err;
  assign prdata = r_reg.rdata;
  assign missed_rollover = r_reg.rollover;
  assign missed_irq = r_reg.rollover && missed_int_enable;

endmodule : mac_station_mgmt_and_counters

// File: hdl/mgmt_serial_engine.sv
// management serial frame engine: mdc divider, shift out, read sampling
`timescale 1ns/1ps
module mgmt_serial_engine
  import station_mgmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic skip_preamble,
  input wire logic [2:0] mgmt_clock_divider,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] wdata,
  input wire logic mdio_in,
  output logic done,
  output logic [15:0] rdata,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe_n
);

  typedef struct packed {
    engine_state_type state;
    logic sync1;
    logic sync2;
    logic [3:0] cnt;
    logic [5:0] idx;
    logic [63:0] frame;
    logic is_read;
    logic mdc;
    logic mdio_out;
    logic oe_n;
    logic done;
    logic [15:0] rdata;
  } engine_type;

  engine_type s_reg;
  engine_type s_next;
  logic [3:0] half;
  logic [5:0] idx_inc;

  always_comb
  begin
    s_next = s_reg;
    half = 4'(mgmt_clock_divider) + MDC_HALF_BASE;
    idx_inc = s_reg.idx + 6'h01;
    s_next.sync1 = mdio_in;
    s_next.sync2 = s_reg.sync1;
    s_next.done = 1'b0;
    unique case (s_reg.state)
      ENG_IDLE:
      begin
        if (start)
        begin
          s_next.frame = {PREAMBLE, START_CODE, is_write ? OP_WRITE : OP_READ,
                          phy_addr, reg_addr, is_write ? TA_WRITE : TA_READ, wdata};
          s_next.idx = skip_preamble ? IDX_FIRST_NO_PRE : IDX_FIRST_FULL;
          s_next.is_read = ~is_write;
          s_next.cnt = 4'h0;
          s_next.mdc = 1'b0;
          s_next.mdio_out = skip_preamble ? START_CODE[1] : PREAMBLE[31];
          s_next.oe_n = 1'b0;
          s_next.state = ENG_RUN;
        end
      end
      ENG_RUN:
      begin
        s_next.cnt = s_reg.cnt + 4'h1;
        if (s_reg.cnt == half - 4'h1)
        begin
          s_next.cnt = 4'h0;
          if (!s_reg.mdc)
          begin
            s_next.mdc = 1'b1;
            // the phy drives read data while mdc is low, so sample at the rise
            if (s_reg.is_read && s_reg.idx >= IDX_DATA)
              s_next.rdata = {s_reg.rdata[14:0], s_reg.sync2};
          end
          else
          begin
            s_next.mdc = 1'b0;
            if (s_reg.idx == IDX_LAST)
            begin
              s_next.state = ENG_IDLE;
              s_next.done = 1'b1;
              s_next.oe_n = 1'b1;
              s_next.mdio_out = 1'b1;
            end
            else
            begin
              s_next.idx = idx_inc;
              s_next.mdio_out = s_reg.frame[6'h3f - idx_inc];
              // release the line from the turnaround onward on reads
              s_next.oe_n = s_reg.is_read && idx_inc >= IDX_TURNAROUND;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.state <= ENG_IDLE;
      s_reg.mdio_out <= 1'b1;
      s_reg.oe_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign done = s_reg.done;
  assign rdata = s_reg.rdata;
  assign mdc = s_reg.mdc;
  assign mdio_out = s_reg.mdio_out;
  assign mdio_oe_n = s_reg.oe_n;

endmodule : mgmt_serial_engine

// File: hdl/station_mgmt_pkg.sv
// constants and types shared by the station management block
package station_mgmt_pkg;

  // register byte offsets on the bus
  localparam logic [15:0] OFF_DATA = 16'ha018;
  localparam logic [15:0] OFF_CONTROL = 16'ha01c;
  localparam logic [15:0] OFF_CAM_MASK = 16'ha028;
  localparam logic [15:0] OFF_MISSED = 16'ha03c;
  localparam logic [15:0] OFF_RX_PAUSE = 16'ha040;
  localparam logic [15:0] OFF_REMOTE_PAUSE = 16'ha044;
  localparam logic [15:0] OFF_ALIGN_TALLY = 16'ha048;
  localparam logic [15:0] OFF_CHECKSUM_TALLY = 16'ha04c;

  // station_mgmt_control field positions
  localparam int CTL_REG_LSB = 0;
  localparam int CTL_PHY_LSB = 5;
  localparam int CTL_WRITE_BIT = 10;
  localparam int CTL_BUSY_BIT = 11;
  localparam int CTL_SKIP_PRE_BIT = 12;
  localparam int CTL_DIV_LSB = 13;

  // reset values
  localparam logic [31:0] DATA_RESET = 32'h00000000;
  localparam logic [31:0] CONTROL_RESET = 32'h00008000;
  localparam logic [31:0] CAM_MASK_RESET = 32'h00000000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0] DIV_RESET = CONTROL_RESET[15:13];

  // cam size and missed counter rollover point
  localparam int CAM_SLOTS = 21;
  localparam int CAM_IMPLEMENTED = 21;
  localparam logic [15:0] MISSED_ROLL_FROM = 16'h7fff;

  // management frame layout, bit 0 is the first bit on the wire
  localparam logic [3:0] MDC_HALF_BASE = 4'h8;
  localparam logic [5:0] IDX_FIRST_FULL = 6'h00;
  localparam logic [5:0] IDX_FIRST_NO_PRE = 6'h20;
  localparam logic [5:0] IDX_TURNAROUND = 6'h2e;
  localparam logic [5:0] IDX_DATA = 6'h30;
  localparam logic [5:0] IDX_LAST = 6'h3f;
  localparam logic [31:0] PREAMBLE = 32'hffffffff;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_READ = 2'h3;

  typedef enum logic {ENG_IDLE, ENG_RUN} engine_state_type;

endpackage : station_mgmt_pkg

// File: tb/mac_station_mgmt_props.sv
// port checks for the station management block
`timescale 1ns/1ps
module mac_station_mgmt_props
  import station_mgmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mdc,
  input wire logic [CAM_SLOTS-1:0] cam_location_valid_bits,
  input wire logic drop_fifo_overflow,
  input wire logic drop_fifo_parity,
  input wire logic drop_rx_disabled,
  input wire logic missed_int_enable,
  input wire logic missed_rollover,
  input wire logic missed_irq
);
  logic [CAM_SLOTS-1:0] cam_want;
  wire drop_any = drop_fifo_overflow | drop_fifo_parity | drop_rx_disabled;
  wire cam_wr = psel && penable && pready && pwrite && paddr == OFF_CAM_MASK;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cam_want <= '0;
    else if (cam_wr)
      cam_want <= pwdata[CAM_SLOTS-1:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_access: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("no ready in first access cycle");
  a_ready_setup: assert property (psel && !penable |-> !pready && !pslverr)
    else $error("answer in setup cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_irq_gate: assert property (missed_irq == (missed_rollover && missed_int_enable))
    else $error("interrupt not gated by enable");
  a_roll_pulse: assert property (missed_rollover |=> !missed_rollover)
    else $error("rollover flag too long");
  a_roll_cause: assert property (missed_rollover |-> $past(drop_any) || $past(drop_any, 2))
    else $error("rollover without dropped packet");
  a_mdc_high: assert property ($rose(mdc) |-> mdc [*8])
    else $error("mdc high half too short");
  a_mdc_low: assert property ($fell(mdc) |-> (!mdc) [*8])
    else $error("mdc low half too short");
  a_cam_copy: assert property (cam_wr |-> ##2 cam_location_valid_bits == cam_want)
    else $error("cam valid bits differ from mask");
  c_rollover: cover property (missed_rollover && missed_irq);
  c_mdc: cover property ($rose(mdc));
  c_unmapped: cover property (pslverr);
endmodule : mac_station_mgmt_props

bind mac_station_mgmt_and_counters mac_station_mgmt_props chk_u (.*);

// File: tb/mgmt_phy_model.sv
// behavioural phy on the management link: records frames, answers reads
`timescale 1ns/1ps
module mgmt_phy_model
(
  input wire logic mdc,
  input wire logic mdio,
  input wire logic [15:0] rd_word,
  output logic drv_en,
  output logic drv_val,
  output logic [31:0] frame
);
  logic [31:0] sr = '1;
  logic busy = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  initial
  begin
    drv_en = 1'b0;
    drv_val = 1'b1;
    frame = '0;
  end
  // start pattern 01 after idle ones; sr refills with ones so data zeros never alias
  always @(posedge mdc)
  begin
    sr <= {sr[30:0], mdio};
    if (!busy && {sr[0], mdio} == 2'b01)
    begin
      busy <= 1'b1;
      n <= 2;
    end
    else if (busy)
    begin
      n <= n + 1;
      if (n == 3)
        rd <= ({sr[0], mdio} == 2'b10);
      if (n == 31)
      begin
        frame <= {sr[30:0], mdio};
        busy <= 1'b0;
        rd <= 1'b0;
        sr <= '1;
        drv_en <= 1'b0;
      end
    end
  end
  // second turnaround bit low, then data msb first; line released before that
  always @(negedge mdc)
  begin
    drv_en <= busy && rd && n >= 15;
    drv_val <= (n >= 16) ? rd_word[31 - n] : 1'b0;
  end
endmodule : mgmt_phy_model

// File: tb/tb_top.sv
// self-checking bench for the station management block
`timescale 1ns/1ps
module tb_top
  import station_mgmt_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, missed_int_enable;
  logic [15:0] paddr, rd_word;
  logic [31:0] pwdata, prdata, phy_frame;
  logic [7:0] ev_bits;
  logic pready, pslverr, mdc, mdio_out, mdio_oe_n, missed_rollover, missed_irq, drv_en, drv_val;
  logic [CAM_SLOTS-1:0] cam_bits;
  int miscompares = 0, n_compared = 0, rises = 0, per = 0, rolls = 0, irqs = 0, cyc = 0;
  time last_rise = 0;
  // pulled-up line: device wins, then phy, else idle high
  wire mdio = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);
  mac_station_mgmt_and_counters dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .cam_location_valid_bits(cam_bits), .drop_fifo_overflow(ev_bits[0]),
    .drop_fifo_parity(ev_bits[1]), .drop_rx_disabled(ev_bits[2]),
    .rx_status_valid(ev_bits[3]), .rx_status_align_err(ev_bits[4]),
    .rx_status_crc_err(ev_bits[5]), .rx_pause_slot(ev_bits[6]),
    .remote_pause_slot(ev_bits[7]), .missed_int_enable(missed_int_enable),
    .missed_rollover(missed_rollover), .missed_irq(missed_irq)
  );
  mgmt_phy_model phy_u (
    .mdc(mdc), .mdio(mdio), .rd_word(rd_word), .drv_en(drv_en), .drv_val(drv_val),
    .frame(phy_frame)
  );
  always #2 pclk = ~pclk;
  always @(posedge mdc)
  begin
    rises++;
    per = int'(($time - last_rise) / 4);
    last_rise = $time;
  end
  // sampled mid-cycle so each one-cycle pulse counts once
  always @(negedge pclk)
  begin
    rolls += missed_rollover;
    irqs += missed_irq;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      close_out;
    end
  end
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer is taken at the rising edge where pready is seen high, or after 20 edges without it
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] apb ready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task rdchk(input logic [15:0] a, input logic [31:0] x, input string s);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(s, x, r);
  endtask : rdchk
  task pulse(input logic [7:0] m);
    ev_bits <= m;
    @(posedge pclk);
    ev_bits <= 8'h00;
    @(posedge pclk);
  endtask : pulse
  task t_reset;
    logic [15:0] a [6];
    logic [31:0] x [6];
    a = '{OFF_DATA, OFF_CONTROL, OFF_CAM_MASK, OFF_MISSED, OFF_RX_PAUSE, OFF_REMOTE_PAUSE};
    x = '{32'h0, 32'h00008000, 32'h0, 32'h0, 32'h0, 32'h0};
    foreach (a[i])
      rdchk(a[i], x[i], "reset value");
  endtask : t_reset
  task t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b1, OFF_CAM_MASK, 32'hffffffff, r, e);
    rdchk(OFF_CAM_MASK, 32'h001fffff, "cam mask");
    chk("cam port", 32'h001fffff, 32'(cam_bits));
    apb(1'b1, OFF_RX_PAUSE, 32'h00001234, r, e);
    rdchk(OFF_RX_PAUSE, 32'h0, "pause read only");
    apb(1'b0, 16'ha020, 32'h0, r, e);
    chk("unmapped error", 32'h1, 32'(e));
  endtask : t_regs
  task t_frame(input logic w, input logic s, input logic [2:0] d, input logic [15:0] v);
    logic [31:0] r, x;
    logic e;
    int k, r0;
    r0 = rises;
    k = 0;
    if (w)
      apb(1'b1, OFF_DATA, {16'h0, v}, r, e);
    x = {16'h0, d, s, 1'b1, w, 5'h13, 5'h0a};
    apb(1'b1, OFF_CONTROL, x, r, e);
    do
    begin
      apb(1'b0, OFF_CONTROL, 32'h0, r, e);
      k++;
    end while (r[11] !== 1'b0 && k < 1000);
    chk("control", x & 32'hfffff7ff, r);
    chk("frame", {2'b01, w ? 2'b01 : 2'b10, 10'h26a, 2'b10, v}, phy_frame);
    chk("mdc edges", s ? 32'd32 : 32'd64, 32'(rises - r0));
    chk("mdc period", 32'(2 * d + 16), 32'(per));
    rdchk(OFF_DATA, {16'h0, v}, "data");
  endtask : t_frame
  task t_missed;
    logic [31:0] r;
    logic e;
    apb(1'b1, OFF_MISSED, 32'h00007fff, r, e);
    pulse(8'h02);
    rdchk(OFF_MISSED, 32'h00008000, "missed masked roll");
    missed_int_enable <= 1'b1;
    apb(1'b1, OFF_MISSED, 32'h00007ffe, r, e);
    pulse(8'h01);
    pulse(8'h04);
    rdchk(OFF_MISSED, 32'h00008000, "missed count");
    rdchk(OFF_MISSED, 32'h0, "missed cleared");
    chk("rollovers", 32'd2, 32'(rolls));
    chk("interrupts", 32'd1, 32'(irqs));
  endtask : t_missed
  task t_tally;
    pulse(8'h18);
    pulse(8'h38);
    pulse(8'h28);
    pulse(8'h08);
    repeat (3) pulse(8'h40);
    repeat (2) pulse(8'h80);
    rdchk(OFF_ALIGN_TALLY, 32'd2, "alignment tally");
    rdchk(OFF_CHECKSUM_TALLY, 32'd1, "checksum tally");
    rdchk(OFF_RX_PAUSE, 32'd3, "rx pause");
    rdchk(OFF_REMOTE_PAUSE, 32'd2, "remote pause");
    rdchk(OFF_MISSED, 32'h0, "status not a drop");
  endtask : t_tally
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    ev_bits = 8'h00;
    missed_int_enable = 1'b0;
    rd_word = 16'h9b2e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_frame(1'b1, 1'b0, 3'h0, 16'ha5c3);
    t_frame(1'b0, 1'b1, 3'h3, 16'h9b2e);
    t_missed;
    t_tally;
    close_out;
  end
endmodule : tb_top
